// *** hdl/tbsc_pkg.sv ***
package tbsc_pkg;
	localparam logic [7:0]  TBSC_OFF_PMC    = 8'h00;
	localparam logic [7:0]  TBSC_OFF_CKS    = 8'h04;
	localparam logic [7:0]  TBSC_OFF_STAT   = 8'h08;
	localparam logic [7:0]  TBSC_OFF_IRQ    = 8'h0C;
	localparam logic [7:0]  TBSC_OFF_RSTF   = 8'h10;
	// power-mode control bit positions
	localparam int          TBSC_B_SLP      = 0;
	localparam int          TBSC_B_STP      = 1;
	localparam int          TBSC_B_TMD      = 2;
	localparam int          TBSC_B_SPL      = 3;
	// clock select bit positions
	localparam int          TBSC_B_SCS      = 0;
	localparam int          TBSC_B_MCS      = 1;
	localparam int          TBSC_B_WS0      = 2;
	localparam int          TBSC_B_SCM      = 4;
	localparam logic [3:0]  TBSC_PMC_RST    = 4'h4;
	localparam logic [3:0]  TBSC_CKS_RST    = 4'h3;
	localparam logic [1:0]  TBSC_WS_PLL_MIN = 2'h2;
	localparam logic [2:0]  TBSC_LVL_THRESH = 3'h7;
	localparam logic [1:0]  TBSC_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  TBSC_RESP_SLVERR = 2'h2;
	localparam int          TBSC_SUB_WAIT_EXP = 14;
	localparam logic [2:0]  TBSC_SRC_EXT    = 3'h1;
	localparam logic [2:0]  TBSC_SRC_TBT    = 3'h2;
	localparam logic [2:0]  TBSC_SRC_WT     = 3'h4;
	localparam logic [1:0]  TBSC_VAR_MAIN   = 2'h0;
	localparam logic [1:0]  TBSC_VAR_PLL    = 2'h1;
	localparam logic [1:0]  TBSC_VAR_SUB    = 2'h2;

	typedef enum logic [2:0] {
		TBSC_RUN     = 3'b000,
		TBSC_TBT     = 3'b001,
		TBSC_STOP    = 3'b010,
		TBSC_OSCWAIT = 3'b011,
		TBSC_RESET   = 3'b100
	} tbsc_state_t;

	typedef struct packed {
		logic       hclk_run;
		logic       sclk_run;
		logic       timers_run;
		logic       lvd_run;
		logic       others_run;
		logic       retain;
		logic       pin_hiz;
		logic       pin_hold;
	} tbsc_ctl_t;
endpackage : tbsc_pkg

// *** hdl/tbsc_ctrl.sv ***
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - writing zero to timer_mode_bit outside subclock mode enters timebase timer mode
// - timebase timer mode runs only clocks, timers and low-voltage detector
// - registers and RAM retained throughout timebase timer and stop modes
// - a pending interrupt blocks timebase timer entry; CPU just continues
// - pin_hold_select picks pin hold or high impedance in standby
// - reset factor in timebase timer mode goes to main clock then reset
// - watch, timebase or external request above level 7 cancels timebase mode
// - after interrupt wake the CPU continues or branches per its acceptance
// - timebase mode returns to the main or PLL clock it came from
// - writing one to stop_request_bit enters main, PLL or sub stop per selects
// - stop mode halts both oscillation clock and subclock
// - stop wins when stop and sleep are written together
// - a pending interrupt blocks stop entry; CPU just continues
// - stop release waits for the oscillator stabilization time
// - reset factor in stop times main wait, then enters reset sequence
// - only external requests above level 7 cancel stop; seen after the wait
// - PLL stop recovery counts main and PLL waits together by osc_wait_select
// - after stop wake the next instruction runs, then the interrupt
// - sub-stop recovery waits a fixed 2^14 subclock periods
// - qualifying interrupts wake regardless of CPU interrupt acceptance
// - pin_hold_select lives in the power-mode control register
module tbsc_ctrl
	import tbsc_pkg::*;
#(
	parameter int MAIN_WAIT_EXP0 = 10,
	parameter int MAIN_WAIT_EXP1 = 13,
	parameter int MAIN_WAIT_EXP2 = 15,
	parameter int MAIN_WAIT_EXP3 = 17
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        irq_pending,
	input  wire logic [2:0]  irq_source,
	input  wire logic [2:0]  request_priority_level,
	input  wire logic        reset_factor,
	output tbsc_ctl_t        ctl,
	output logic             cpu_resume,
	output logic             reset_seq_req
);
	tbsc_state_t state_r, state_nxt;
	logic [3:0]  pmc_r;
	logic [3:0]  cks_r;
	logic [1:0]  var_r;
	logic        rst_wake_r;
	logic [17:0] wcnt_r;
	logic [17:0] wlimit;
	logic        aw_hold_r, w_hold_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        irq_s1_r, irq_s2_r, rf_s1_r, rf_s2_r;
	logic [2:0]  src_s1_r, src_s2_r, lvl_s1_r, lvl_s2_r;
	logic        resume_r, rstreq_r;
	tbsc_ctl_t   ctl_r;

	// two-stage capture of the external wake and reset inputs
	always_ff @(posedge aclk) begin
		irq_s1_r <= irq_pending;
		irq_s2_r <= irq_s1_r;
		src_s1_r <= irq_source;
		src_s2_r <= src_s1_r;
		lvl_s1_r <= request_priority_level;
		lvl_s2_r <= lvl_s1_r;
		rf_s1_r  <= reset_factor;
		rf_s2_r  <= rf_s1_r;
	end

	function automatic logic [17:0] wait_len(input logic [1:0] ws);
		case (ws)
			2'h0:    wait_len = 18'(1) << MAIN_WAIT_EXP0;
			2'h1:    wait_len = 18'(1) << MAIN_WAIT_EXP1;
			2'h2:    wait_len = 18'(1) << MAIN_WAIT_EXP2;
			default: wait_len = 18'(1) << MAIN_WAIT_EXP3;
		endcase
	endfunction : wait_len

	// smaller level value means higher priority; level 7 never wakes
	wire        lvl_ok   = lvl_s2_r < TBSC_LVL_THRESH;
	wire        tbt_wake = irq_s2_r && lvl_ok && ((src_s2_r & (TBSC_SRC_EXT | TBSC_SRC_TBT | TBSC_SRC_WT)) != 3'h0);
	wire        stp_wake = irq_s2_r && lvl_ok && ((src_s2_r & TBSC_SRC_EXT) != 3'h0);
	wire        sub_sel  = ~cks_r[TBSC_B_SCS];
	wire [1:0]  ws       = pmc_ws();
	wire [1:0]  stop_var = sub_sel ? TBSC_VAR_SUB :
	                       (cks_r[TBSC_B_MCS] ? TBSC_VAR_MAIN : TBSC_VAR_PLL);

	function automatic logic [1:0] pmc_ws();
		pmc_ws = cks_r[TBSC_B_WS0 +: 2];
	endfunction : pmc_ws

	// bus write decode
	wire        wr_fire   = aw_hold_r && w_hold_r && !s_axi_bvalid;
	wire        wr_pmc    = wr_fire && awaddr_r == TBSC_OFF_PMC && wstrb_r[0];
	wire        wr_cks    = wr_fire && awaddr_r == TBSC_OFF_CKS && wstrb_r[0];
	wire        wr_ok     = awaddr_r == TBSC_OFF_PMC || awaddr_r == TBSC_OFF_CKS;
	wire        in_run    = state_r == TBSC_RUN;
	wire        req_stp   = wr_pmc && in_run && wdata_r[TBSC_B_STP];
	wire        req_tmd   = wr_pmc && in_run && !wdata_r[TBSC_B_TMD] && !sub_sel;
	wire        enter_stp = req_stp && !irq_s2_r;
	wire        enter_tbt = req_tmd && !req_stp && !irq_s2_r;
	wire        wait_done = wcnt_r >= wlimit;

	always_comb begin
		if (var_r == TBSC_VAR_SUB && !rst_wake_r)
			wlimit = 18'(1) << TBSC_SUB_WAIT_EXP;
		else
			wlimit = wait_len(ws);
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TBSC_RUN: begin
				if (enter_stp)
					state_nxt = TBSC_STOP;
				else if (enter_tbt)
					state_nxt = TBSC_TBT;
			end
			TBSC_TBT: begin
				if (rf_s2_r)
					state_nxt = TBSC_RESET;
				else if (tbt_wake)
					state_nxt = TBSC_RUN;
			end
			TBSC_STOP: begin
				if (rf_s2_r || stp_wake)
					state_nxt = TBSC_OSCWAIT;
			end
			TBSC_OSCWAIT: begin
				if (wait_done)
					state_nxt = rst_wake_r ? TBSC_RESET : TBSC_RUN;
			end
			TBSC_RESET: state_nxt = TBSC_RUN;
			default:    state_nxt = TBSC_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= TBSC_RUN;
			var_r      <= TBSC_VAR_MAIN;
			rst_wake_r <= 1'b0;
			wcnt_r     <= 18'h0;
		end else begin
			state_r <= state_nxt;
			if (enter_stp)
				var_r <= stop_var;
			else if (enter_tbt)
				var_r <= cks_r[TBSC_B_MCS] ? TBSC_VAR_MAIN : TBSC_VAR_PLL;
			if (state_r == TBSC_STOP)
				rst_wake_r <= rf_s2_r;
			wcnt_r <= (state_r == TBSC_OSCWAIT) ? wcnt_r + 18'h1 : 18'h0;
		end
	end

	// control registers; wake restores run values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pmc_r <= TBSC_PMC_RST;
			cks_r <= TBSC_CKS_RST;
		end else begin
			if (wr_pmc)
				pmc_r <= wdata_r[3:0];
			if (state_r != TBSC_RUN && state_nxt == TBSC_RUN) begin
				pmc_r[TBSC_B_TMD] <= 1'b1;
				pmc_r[TBSC_B_STP] <= 1'b0;
				pmc_r[TBSC_B_SLP] <= 1'b0;
			end else if (wr_pmc && (irq_s2_r || !in_run)) begin
				pmc_r[TBSC_B_TMD] <= 1'b1;
				pmc_r[TBSC_B_STP] <= 1'b0;
			end
			if (wr_cks && in_run)
				cks_r <= wdata_r[3:0];
			if (state_nxt == TBSC_RESET)
				cks_r[TBSC_B_MCS] <= 1'b1;
		end
	end

	wire in_tbt  = state_r == TBSC_TBT;
	wire in_stop = state_r == TBSC_STOP || state_r == TBSC_OSCWAIT;
	wire standby = in_tbt || in_stop;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_r    <= '0;
			resume_r <= 1'b0;
			rstreq_r <= 1'b0;
		end else begin
			ctl_r.hclk_run   <= !in_stop;
			ctl_r.sclk_run   <= !in_stop;
			ctl_r.timers_run <= !in_stop;
			ctl_r.lvd_run    <= !in_stop;
			ctl_r.others_run <= !standby;
			ctl_r.retain     <= standby;
			ctl_r.pin_hiz    <= standby && pmc_r[TBSC_B_SPL];
			ctl_r.pin_hold   <= standby && !pmc_r[TBSC_B_SPL];
			resume_r         <= standby && state_nxt == TBSC_RUN;
			rstreq_r         <= state_nxt == TBSC_RESET;
		end
	end
	assign ctl           = ctl_r;
	assign cpu_resume    = resume_r;
	assign reset_seq_req = rstreq_r;

	// AXI4-Lite slave, one write and one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			awaddr_r     <= 8'h0;
			wdata_r      <= 32'h0;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= TBSC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? TBSC_RESP_OKAY : TBSC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;

	wire [31:0] rd_pmc  = {28'h0, pmc_r};
	wire [31:0] rd_cks  = {27'h0, !sub_sel, cks_r[TBSC_B_WS0 +: 2], cks_r[1:0]};
	wire [31:0] rd_stat = {27'h0, var_r, state_r};
	wire [31:0] rd_irq  = {25'h0, irq_s2_r, src_s2_r, lvl_s2_r};
	wire [31:0] rd_mux  = (s_axi_araddr == TBSC_OFF_PMC)  ? rd_pmc :
	                      (s_axi_araddr == TBSC_OFF_CKS)  ? rd_cks :
	                      (s_axi_araddr == TBSC_OFF_STAT) ? rd_stat :
	                      (s_axi_araddr == TBSC_OFF_IRQ)  ? rd_irq : 32'h0;
	wire        rd_ok   = s_axi_araddr == TBSC_OFF_PMC || s_axi_araddr == TBSC_OFF_CKS ||
	                      s_axi_araddr == TBSC_OFF_STAT || s_axi_araddr == TBSC_OFF_IRQ;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= TBSC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? TBSC_RESP_OKAY : TBSC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

	property p_stp_block;
		@(posedge aclk) disable iff (!aresetn) (req_stp && irq_s2_r) |=> state_r == TBSC_RUN;
	endproperty
	a_stp_block: assert property (p_stp_block) else $error("stop entered with interrupt pending");
	property p_tbt_block;
		@(posedge aclk) disable iff (!aresetn) (req_tmd && irq_s2_r) |=> state_r == TBSC_RUN;
	endproperty
	a_tbt_block: assert property (p_tbt_block) else $error("timebase entered with interrupt pending");
	property p_stp_prio;
		@(posedge aclk) disable iff (!aresetn) (req_stp && !irq_s2_r && wdata_r[TBSC_B_SLP]) |=> state_r == TBSC_STOP;
	endproperty
	a_stp_prio: assert property (p_stp_prio) else $error("stop lost priority");
	property p_tbt_enter;
		@(posedge aclk) disable iff (!aresetn) (enter_tbt) |=> state_r == TBSC_TBT ##1 ctl.others_run == 1'b0;
	endproperty
	a_tbt_enter: assert property (p_tbt_enter) else $error("timebase mode not entered");
	property p_stop_clk;
		@(posedge aclk) disable iff (!aresetn) (state_r == TBSC_STOP) |=> !ctl.hclk_run && !ctl.sclk_run;
	endproperty
	a_stop_clk: assert property (p_stop_clk) else $error("clock running in stop");
	property p_tbt_rst;
		@(posedge aclk) disable iff (!aresetn) (state_r == TBSC_TBT && rf_s2_r) |=> state_r == TBSC_RESET && cks_r[TBSC_B_MCS];
	endproperty
	a_tbt_rst: assert property (p_tbt_rst) else $error("reset factor not taken to main clock");
	sequence s_wait_run;
		state_r == TBSC_OSCWAIT && !wait_done;
	endsequence
	property p_wait;
		@(posedge aclk) disable iff (!aresetn) s_wait_run |=> state_r == TBSC_OSCWAIT;
	endproperty
	a_wait: assert property (p_wait) else $error("stop left before stabilization");
	property p_stop_nowake;
		@(posedge aclk) disable iff (!aresetn) (state_r == TBSC_STOP && !rf_s2_r && !stp_wake) |=> state_r == TBSC_STOP;
	endproperty
	a_stop_nowake: assert property (p_stop_nowake) else $error("stop left without external wake");
	property p_clear;
		@(posedge aclk) disable iff (!aresetn) (cpu_resume) |-> pmc_r[TBSC_B_TMD] && !pmc_r[TBSC_B_STP];
	endproperty
	a_clear: assert property (p_clear) else $error("mode bits not restored on wake");
	property p_pins;
		@(posedge aclk) disable iff (!aresetn) (state_r == TBSC_TBT && $stable(state_r)) |=> ctl.pin_hiz == pmc_r[TBSC_B_SPL];
	endproperty
	a_pins: assert property (p_pins) else $error("pin state disagrees with hold select");
endmodule : tbsc_ctrl

// *** tb/tbsc_cpu_model.sv ***
`timescale 1ns/1ns
// cpu side: issues register writes and reads one at a time
module tbsc_cpu_model
	import tbsc_pkg::*;
(
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// peripheral outputs are taken as already off before any standby write
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_ok;
		logic w_ok;
		logic aw_hit;
		logic w_hit;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(negedge aclk);
			aw_hit = awvalid && awready;
			w_hit  = wvalid && wready;
			@(posedge aclk);
			// released payload must not look valid
			if (aw_hit) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
				aw_ok = 1'b1;
			end
			if (w_hit) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
				w_ok = 1'b1;
			end
		end
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw_hit = bvalid;
			resp   = bresp;
			@(posedge aclk);
		end while (!aw_hit);
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic hit;
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			hit = arready;
			@(posedge aclk);
		end while (!hit);
		arvalid <= 1'b0;
		araddr  <= ~a;
		rready  <= 1'b1;
		do begin
			@(negedge aclk);
			hit  = rvalid;
			d    = rdata;
			resp = rresp;
			@(posedge aclk);
		end while (!hit);
		rready <= 1'b0;
	endtask : axi_read
endmodule : tbsc_cpu_model

// *** tb/tb_tbsc_ctrl.sv ***
`timescale 1ns/1ns
module tb_tbsc_ctrl
	import tbsc_pkg::*;
;
	logic        aclk = 1'b0;
	logic        aresetn;
	wire  [7:0]  awaddr, araddr;
	wire  [31:0] wdata, rdata;
	wire  [3:0]  wstrb;
	wire  [1:0]  bresp, rresp;
	wire         awvalid, awready, wvalid, wready, bvalid, bready;
	wire         arvalid, arready, rvalid, rready;
	logic        irq_pending;
	logic [2:0]  irq_source;
	logic [2:0]  request_priority_level;
	logic        reset_factor;
	tbsc_ctl_t   ctl;
	logic        cpu_resume;
	logic        reset_seq_req;
	int          err_total = 0;
	int          samples_checked = 0;
	int          n;
	logic [31:0] rd;
	logic [1:0]  rr;
	logic [7:0]  cks_tab [3] = '{8'h03, 8'h09, 8'h0E};
	logic [1:0]  var_tab [3] = '{TBSC_VAR_MAIN, TBSC_VAR_PLL, TBSC_VAR_SUB};
	int          wait_tab [3] = '{4, 16, 32};

	always #5 aclk = ~aclk;

	// short waits: exponents 2,3,4,5 stand for the long oscillator counts
	tbsc_ctrl #(.MAIN_WAIT_EXP0(2), .MAIN_WAIT_EXP1(3), .MAIN_WAIT_EXP2(4), .MAIN_WAIT_EXP3(5)) tbsc_ctrl_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_pending(irq_pending), .irq_source(irq_source),
		.request_priority_level(request_priority_level), .reset_factor(reset_factor),
		.ctl(ctl), .cpu_resume(cpu_resume), .reset_seq_req(reset_seq_req)
	);

	tbsc_cpu_model cpu_i (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
	);

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		cpu_i.axi_read(a, rd, rr);
		chk(rd & m, e, s);
	endtask : rd_chk

	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask : settle

	// hold the reset factor until the reset sequence request shows; n counts the wait
	task automatic wake_by_reset;
		n = 0;
		reset_factor <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (reset_seq_req !== 1'b1 && n < 400);
		@(posedge aclk);
		reset_factor <= 1'b0;
		repeat (10) @(posedge aclk);
	endtask : wake_by_reset

	initial begin
		aresetn = 1'b0;
		irq_pending = 1'b0;
		irq_source = 3'h0;
		request_priority_level = 3'h0;
		reset_factor = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		rd_chk(TBSC_OFF_PMC, 32'h0000000F, {28'h0, TBSC_PMC_RST}, "pmc reset");
		rd_chk(TBSC_OFF_CKS, 32'h0000001F, 32'h00000013, "cks reset");
		rd_chk(TBSC_OFF_STAT, 32'h0000001F, 32'h00000000, "state reset");
		cpu_i.axi_read(8'h14, rd, rr);
		chk({30'h0, rr}, {30'h0, TBSC_RESP_SLVERR}, "unmapped read resp");
		chk(rd, 32'h00000000, "unmapped read data");
		cpu_i.axi_write(8'h18, 32'h00000000, rr);
		chk({30'h0, rr}, {30'h0, TBSC_RESP_SLVERR}, "unmapped write resp");
		$display("test registers done");
		// entry attempts while a request is pending must be refused
		irq_pending <= 1'b1;
		irq_source <= TBSC_SRC_EXT;
		request_priority_level <= 3'h7;
		settle();
		cpu_i.axi_write(TBSC_OFF_PMC, 32'h00000000, rr);
		settle();
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000000, "tbt refused");
		rd_chk(TBSC_OFF_PMC, 32'h00000004, 32'h00000004, "tmd restored");
		cpu_i.axi_write(TBSC_OFF_PMC, 32'h00000006, rr);
		settle();
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000000, "stop refused");
		rd_chk(TBSC_OFF_PMC, 32'h00000002, 32'h00000000, "stp restored");
		irq_pending <= 1'b0;
		settle();
		$display("test pending refusal done");
		cpu_i.axi_write(TBSC_OFF_PMC, 32'h00000000, rr);
		settle();
		chk({24'h0, ctl}, 32'h000000F5, "tbt controls");
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000001, "tbt entered");
		// level 7 is not above the threshold, so no wake
		irq_pending <= 1'b1;
		repeat (10) @(posedge aclk);
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000001, "level 7 no wake");
		chk({31'h0, cpu_resume}, 32'h00000000, "no resume");
		irq_pending <= 1'b0;
		wake_by_reset();
		chk({31'h0, n < 400}, 32'h00000001, "tbt reset wake");
		rd_chk(TBSC_OFF_PMC, 32'h00000004, 32'h00000004, "tmd back");
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000000, "run after reset");
		cpu_i.axi_write(TBSC_OFF_PMC, 32'h00000000, rr);
		settle();
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000001, "tbt again");
		request_priority_level <= 3'h3;
		irq_pending <= 1'b1;
		repeat (10) @(posedge aclk);
		rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000000, "irq wake");
		rd_chk(TBSC_OFF_PMC, 32'h00000004, 32'h00000004, "tmd after irq wake");
		irq_pending <= 1'b0;
		settle();
		$display("test timebase mode done");
		for (int i = 0; i < 3; i++) begin
			cpu_i.axi_write(TBSC_OFF_CKS, {24'h0, cks_tab[i]}, rr);
			cpu_i.axi_write(TBSC_OFF_PMC, 32'h0000000F, rr);
			settle();
			chk({24'h0, ctl}, 32'h00000006, "stop controls");
			rd_chk(TBSC_OFF_STAT, 32'h0000001F, {27'h0, var_tab[i], 3'h2}, "stop variant");
			request_priority_level <= 3'h7;
			irq_pending <= 1'b1;
			repeat (40) @(posedge aclk);
			rd_chk(TBSC_OFF_STAT, 32'h00000007, 32'h00000002, "stop held");
			irq_pending <= 1'b0;
			wake_by_reset();
			chk({31'h0, n >= wait_tab[i] && n < 400}, 32'h00000001, "osc wait");
			rd_chk(TBSC_OFF_PMC, 32'h00000002, 32'h00000000, "stp back");
		end
		$display("test stop modes done");
		complete_run();
	end

	initial begin
		#200000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
endmodule : tb_tbsc_ctrl
